// ---- hdl/ussu_core.sv ----
// universal serial shift unit: shift register, counter, start detect, hold
// Function
// - link clock at most half core clock
// - each toggle strobe toggles clock, counts once
// - status write with flag clears it, loads counter
// - two-wire protocol without slew or filtering
// - master clocks bus, slave uses hold
// - start detect sets start flag
// - hold clock low after start until cleared
// - slave shifts data on clock rise, or on fall with edge select set
// - eight bits overflow, and in mode three hold clock low
// - start detector only in two-wire mode
// - start detector is sampled, needs running core clock
// - slave holds clock until ready
// - external clock counts both edges
// - counter at fifteen overflows next edge
// - strobes can trigger overflow from software
// - counter chains with timer as twelve bits
// - three-wire slave keeps shifting past overflow, no hold
// - mode zero disables outputs, hold, detect
// - clock edge select picks sample edge
// - msb drives output via latch
`timescale 1ns/1ns
module ussu_core
    import ussu_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic [1:0] i_wire_mode_field,
    input  wire logic       i_clk_source_bit1,
    input  wire logic       i_clk_edge_select,
    input  wire logic       i_strobe_clock_select,
    input  wire logic       i_ctrl_wr,
    input  wire logic       i_clock_toggle_strobe,
    input  wire logic       i_status_wr,
    input  wire logic       i_status_ovf_clr,
    input  wire logic       i_status_start_clr,
    input  wire logic [3:0] i_status_count,
    input  wire logic       i_data_wr,
    input  wire logic [7:0] i_data_wdata,
    input  wire logic       i_timer_match,
    input  wire logic       i_serial_clock_pin,
    input  wire logic       i_serial_in_pin,
    output logic [7:0]      o_shift_data_reg,
    output logic [3:0]      o_count,
    output logic            o_counter_overflow_flag,
    output logic            o_start_cond_flag,
    output logic            o_data_out,
    output logic            o_sda_oe,
    output logic            o_scl_oe,
    output logic            o_sck_out
);
`include "ussu_cfg.svh"
    ////////////////////////////////////////////////////////////////////////
    logic sck_lvl;
    logic sck_rise;
    logic sck_fall;
    logic sdi_lvl;
    logic sdi_fall;
    // pin edges are only seen if each half period spans a core cycle
    ussu_edge_sync u_sck_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_pin   (i_serial_clock_pin),
        .o_level (sck_lvl),
        .o_rise  (sck_rise),
        .o_fall  (sck_fall)
    );
    ussu_edge_sync u_sdi_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_pin   (i_serial_in_pin),
        .o_level (sdi_lvl),
        .o_rise  (),
        .o_fall  (sdi_fall)
    );
    ////////////////////////////////////////////////////////////////////////
    ussu_state_t st_q;
    ussu_state_t st_d;
    logic       two_wire;
    logic       outputs_on;
    logic       ext_src;
    logic       strobe;
    logic       strobe_rise;
    logic       strobe_fall;
    logic       cnt_tick;
    logic       shift_tick;
    logic       out_tick;
    logic       wrap;
    logic       start_seen;
    always_comb begin
        two_wire   = i_wire_mode_field[1];
        outputs_on = i_wire_mode_field != `USSU_WM_OFF;
        ext_src    = i_clk_source_bit1;
        strobe     = i_ctrl_wr & i_clock_toggle_strobe;
        // strobe toggles the clock output; the new level tells the edge
        strobe_rise = strobe & ~st_q.sck_out;
        strobe_fall = strobe & st_q.sck_out;
        // external pin: both edges count, software strobe counts once
        if (ext_src) begin
            cnt_tick = i_strobe_clock_select ? strobe
                                             : (sck_rise | sck_fall);
        end else begin
            cnt_tick = i_strobe_clock_select ? strobe
                                             : i_timer_match;
        end
        // data sampling edge per edge select; software clocking uses strobe
        if (ext_src & ~i_strobe_clock_select) begin
            shift_tick = i_clk_edge_select ? sck_fall : sck_rise;
            out_tick   = i_clk_edge_select ? sck_rise : sck_fall;
        end else if (ext_src) begin
            shift_tick = strobe_rise;
            out_tick   = strobe_fall;
        end else begin
            shift_tick = i_strobe_clock_select ? strobe : i_timer_match;
            out_tick   = shift_tick;
        end
        wrap       = cnt_tick & (st_q.count == `USSU_CNT_MAX);
        // scl high while sda falls; synchronised samples need no delay line
        // limitation: sampled detector, so a wake-up needs the core clock
        start_seen = two_wire & sck_lvl & sdi_fall;
    end
    always_comb begin
        st_d = st_q;
        if (strobe) begin
            st_d.sck_out = ~st_q.sck_out;
        end
        if (shift_tick) begin
            st_d.shift_data_reg = {st_q.shift_data_reg[6:0],
                                   sdi_lvl};
        end
        if (i_data_wr) begin
            st_d.shift_data_reg = i_data_wdata;
        end
        if (cnt_tick) begin
            st_d.count = st_q.count + 4'h1;
        end
        if (i_status_wr) begin
            st_d.count = i_status_count;
        end
        if (i_status_wr & i_status_ovf_clr) begin
            st_d.counter_overflow_flag = 1'b0;
            st_d.hold_ovf = 1'b0;
        end
        if (wrap) begin
            st_d.counter_overflow_flag = 1'b1;
            st_d.hold_ovf = two_wire & i_wire_mode_field[0];
        end
        if (i_status_wr & i_status_start_clr) begin
            st_d.start_cond_flag = 1'b0;
            st_d.hold_start = 1'b0;
        end
        if (start_seen) begin
            st_d.start_cond_flag = 1'b1;
        end
        if (two_wire & st_q.start_cond_flag & sck_fall) begin
            st_d.hold_start = 1'b1;
        end
        if (!two_wire) begin
            st_d.hold_start = 1'b0;
            st_d.hold_ovf   = 1'b0;
        end
        // output latch: msb moves to the pin on out_tick (opposite edge whenever the external source is selected), on data write, or while off
        if (out_tick | i_data_wr | ~outputs_on) begin
            st_d.dout = st_d.shift_data_reg[`USSU_DATA_MSB];
        end
        // open drain, no slew control or filtering on these pins
        st_d.sda_low = two_wire & ~st_d.dout;
        // scl is pulled by the slave hold path or by a low o_sck_out
        st_d.scl_low = two_wire & (st_d.hold_start | st_d.hold_ovf
                                   | ~st_d.sck_out);
        if (!outputs_on) begin
            st_d.sda_low = 1'b0;
            st_d.scl_low = 1'b0;
        end
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            st_q <= '{shift_data_reg: `USSU_DATA_RST, count: `USSU_CNT_RST,
                      counter_overflow_flag: 1'b0, start_cond_flag: 1'b0,
                      hold_start: 1'b0, hold_ovf: 1'b0, sck_out: 1'b1,
                      dout: 1'b0, sda_low: 1'b0, scl_low: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    assign o_shift_data_reg        = st_q.shift_data_reg;
    assign o_count                 = st_q.count;
    assign o_counter_overflow_flag = st_q.counter_overflow_flag;
    assign o_start_cond_flag       = st_q.start_cond_flag;
    assign o_data_out              = st_q.dout;
    assign o_sda_oe                = st_q.sda_low;
    assign o_scl_oe                = st_q.scl_low;
    assign o_sck_out               = st_q.sck_out;
    ////////////////////////////////////////////////////////////////////////
    // steps used by the properties; all but s_start_drop are shared by two
    sequence s_strobe_now;
        strobe && !i_status_wr;
    endsequence
    sequence s_wrap_now;
        wrap && !i_status_wr;
    endsequence
    sequence s_pin_edge;
        ext_src && !i_strobe_clock_select && (sck_rise || sck_fall);
    endsequence
    sequence s_start_drop;
        i_status_wr && i_status_start_clr && i_status_ovf_clr;
    endsequence

    a_strobe_toggle: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        s_strobe_now |=> o_sck_out != $past(o_sck_out))
        else $error("strobe did not toggle clock");

    a_strobe_count: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (s_strobe_now and i_strobe_clock_select) |=>
        o_count == $past(o_count) + 4'h1)
        else $error("strobe did not advance counter");
    a_status_load: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_status_wr |=> o_count == $past(i_status_count))
        else $error("counter not loaded");

    a_ovf_clear: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_status_wr && i_status_ovf_clr && !wrap) |=>
        !o_counter_overflow_flag)
        else $error("overflow flag not cleared");
    a_ovf_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        s_wrap_now |=> o_counter_overflow_flag && o_count == 4'h0)
        else $error("overflow flag not set on wrap");

    a_ovf_sticky: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (o_counter_overflow_flag && !i_status_wr) |=>
        o_counter_overflow_flag)
        else $error("overflow flag dropped");
    a_start_mode: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (!two_wire && !o_start_cond_flag) |=> !o_start_cond_flag)
        else $error("start flag outside two-wire");

    a_start_set: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        start_seen |=> o_start_cond_flag)
        else $error("start not flagged");

    a_off_quiet: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_wire_mode_field == `USSU_WM_OFF)[*2] |-> !o_sda_oe && !o_scl_oe)
        else $error("outputs driven in off mode");

    a_ovf_hold: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (s_wrap_now and i_wire_mode_field == 2'h3) |=> o_scl_oe)
        else $error("scl not held after overflow");

    a_start_hold: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (two_wire && o_start_cond_flag && sck_fall) |=> o_scl_oe)
        else $error("scl not held after start");

    a_hold_release: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (s_start_drop and (!cnt_tick && !strobe && !sck_fall && o_sck_out))
        |=> !o_scl_oe)
        else $error("scl hold not released");

    a_start_sticky: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (o_start_cond_flag && !i_status_wr) |=> o_start_cond_flag)
        else $error("start flag dropped");

    a_start_clear: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_status_wr && i_status_start_clr && !start_seen) |=>
        !o_start_cond_flag)
        else $error("start flag not cleared");
    a_count_idle: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (!cnt_tick && !i_status_wr) |=> o_count == $past(o_count))
        else $error("counter moved without a tick");

    a_pin_count: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (s_pin_edge and !i_status_wr) |=> o_count == $past(o_count) + 4'h1)
        else $error("pin edge not counted");

    a_timer_count: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (!ext_src && !i_strobe_clock_select && i_timer_match && !i_status_wr)
        |=> o_count == $past(o_count) + 4'h1)
        else $error("timer match not counted");

    a_edge_irq: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (s_pin_edge and (o_count == 4'hf && !i_status_wr)) |=>
        o_counter_overflow_flag && o_count == 4'h0)
        else $error("pin edge at fifteen did not overflow");
    a_shift_in: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (shift_tick && !i_data_wr) |=>
        o_shift_data_reg == {$past(o_shift_data_reg[6:0]), $past(sdi_lvl)})
        else $error("data not shifted in");

    a_mode0_sample: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (ext_src && !i_strobe_clock_select && !i_clk_edge_select
         && sck_rise && !i_data_wr) |=> o_shift_data_reg[0] == $past(sdi_lvl))
        else $error("mode zero did not sample on rise");

    a_mode1_sample: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (ext_src && !i_strobe_clock_select && i_clk_edge_select
         && sck_fall && !i_data_wr) |=> o_shift_data_reg[0] == $past(sdi_lvl))
        else $error("mode one did not sample on fall");

    a_data_load: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        i_data_wr |=> o_shift_data_reg == $past(i_data_wdata)
        && o_data_out == $past(i_data_wdata[7]))
        else $error("data write not loaded");

    a_dout_steady: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (!out_tick && !i_data_wr && outputs_on) |=>
        o_data_out == $past(o_data_out))
        else $error("data out changed off its edge");
    a_sda_follow: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        $past(i_rst_b) |-> o_sda_oe == ($past(two_wire) && !o_data_out))
        else $error("sda drive does not follow data out");

    a_three_no_oe: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        !two_wire |=> !o_sda_oe && !o_scl_oe)
        else $error("open drain driven outside two-wire");

    a_hold_stays: assert property (
        @(posedge i_clock) disable iff (!i_rst_b)
        (o_scl_oe && two_wire && !i_status_wr && !strobe) |=> o_scl_oe)
        else $error("scl hold lost before release");
endmodule : ussu_core

// ---- hdl/ussu_cfg.svh ----
// constants for the universal serial shift unit
`ifndef USSU_CFG_SVH
`define USSU_CFG_SVH
`define USSU_WM_OFF      2'h0
`define USSU_WM_THREE    2'h1
`define USSU_WM_TWO      2'h2
`define USSU_CNT_MAX     4'hf
`define USSU_CNT_RST     4'h0
`define USSU_DATA_RST    8'h00
`define USSU_DATA_MSB    7
`define USSU_CS_SW       2'h0
`define USSU_CS_TIMER    2'h1
`define USSU_CS_EXT      2'h2
`endif

// ---- hdl/ussu_pkg.sv ----
// types for the universal serial shift unit
package ussu_pkg;
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       prev;
    } ussu_sync_t;
    typedef struct packed {
        logic [7:0] shift_data_reg;
        logic [3:0] count;
        logic       counter_overflow_flag;
        logic       start_cond_flag;
        logic       hold_start;
        logic       hold_ovf;
        logic       sck_out;
        logic       dout;
        logic       sda_low;
        logic       scl_low;
    } ussu_state_t;
endpackage : ussu_pkg

// ---- hdl/ussu_edge_sync.sv ----
// two-flop synchroniser with edge detection
`timescale 1ns/1ns
module ussu_edge_sync
    import ussu_pkg::*;
(
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    ussu_sync_t state_q;
    ussu_sync_t state_d;
    always_comb begin
        state_d      = state_q;
        state_d.s1   = i_pin;
        state_d.s2   = state_q.s1;
        state_d.prev = state_q.s2;
    end
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            state_q <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1};
        end else begin
            state_q <= state_d;
        end
    end
    assign o_level = state_q.s2;
    assign o_rise  = state_q.s2 & ~state_q.prev;
    assign o_fall  = ~state_q.s2 & state_q.prev;
endmodule : ussu_edge_sync

// ---- verification/ussu_master_model.sv ----
// partner model: serial master driving the clock and data pins
`timescale 1ns/1ns
module ussu_master_model (
    input  wire logic i_scl_wire,
    output logic      o_scl,
    output logic      o_sda
);
    logic stuck = 1'b0;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // 62/63 ns half periods stay far below half the core rate
    task automatic set_scl(input logic v);
        o_scl = v;
        #63;
    endtask : set_scl
    task automatic start_cond();
        o_sda = 1'b0;
        #62;
        set_scl(1'b0);
    endtask : start_cond
    task automatic stop_cond();
        set_scl(1'b1);
        o_sda = 1'b1;
        #62;
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] b);
        int n;
        for (int i = 7; i >= 0; i--) begin
            o_sda = b[i];
            #62;
            o_scl = 1'b1;
            #62;
            n = 0;
            // a slave may stretch: wait for the wire to really rise
            while (i_scl_wire !== 1'b1 && n < 200) begin
                #10;
                n++;
            end
            if (n >= 200) begin
                stuck = 1'b1;
            end
            set_scl(1'b0);
        end
        // no ack from the far slave; released sda goes to its pull-up
        o_sda = 1'b1;
    endtask : send_byte
endmodule : ussu_master_model

// ---- verification/ussu_core_tb.sv ----
// self-checking bench for the universal serial shift unit
`timescale 1ns/1ns
module ussu_core_tb;
    logic       clk = 1'b0, rst_b = 1'b0, cs1 = 1'b0, edge_s = 1'b0;
    logic       str_sel = 1'b0, ctrl_wr = 1'b0, tgl = 1'b0, tmr = 1'b0;
    logic       st_wr = 1'b0, st_ovf = 1'b0, st_start = 1'b0, d_wr = 1'b0;
    logic [1:0] wm = 2'h0;
    logic [3:0] st_cnt = 4'h0, cnt;
    logic [7:0] d_wd = 8'h00, sdr;
    logic       m_scl, m_sda, ovf, sif, dout, sda_oe, scl_oe, sck;
    logic       scl_w, sda_w;
    int         error_cnt = 0, compares = 0;
    // open-drain wires with pull-ups
    assign scl_w = m_scl & ~scl_oe;
    assign sda_w = m_sda & ~sda_oe;
    always #5 clk = ~clk;
    ussu_core uut (
        .i_clock(clk), .i_rst_b(rst_b), .i_wire_mode_field(wm),
        .i_clk_source_bit1(cs1), .i_clk_edge_select(edge_s),
        .i_strobe_clock_select(str_sel), .i_ctrl_wr(ctrl_wr),
        .i_clock_toggle_strobe(tgl), .i_status_wr(st_wr),
        .i_status_ovf_clr(st_ovf), .i_status_start_clr(st_start),
        .i_status_count(st_cnt), .i_data_wr(d_wr), .i_data_wdata(d_wd),
        .i_timer_match(tmr), .i_serial_clock_pin(scl_w),
        .i_serial_in_pin(sda_w), .o_shift_data_reg(sdr), .o_count(cnt),
        .o_counter_overflow_flag(ovf), .o_start_cond_flag(sif),
        .o_data_out(dout), .o_sda_oe(sda_oe), .o_scl_oe(scl_oe),
        .o_sck_out(sck)
    );
    ussu_master_model pm (.i_scl_wire(scl_w), .o_scl(m_scl), .o_sda(m_sda));
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic check(input string nm, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : check
    task automatic stat(input logic oc, sc, input logic [3:0] c);
        {st_wr, st_ovf, st_start, st_cnt} = {1'b1, oc, sc, c};
        step(1);
        st_wr = 1'b0;
        step(1);
    endtask : stat
    task automatic end_sim();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////
    task automatic t_strobe();
        {wm, cs1, str_sel} = {2'h1, 1'b1, 1'b1};
        stat(1'b1, 1'b0, 4'h0);
        {ctrl_wr, tgl} = 2'b11;
        for (int i = 1; i <= 16; i++) begin
            step(1);
            check("sck", {7'h0, ~i[0]}, {7'h0, sck});
            check("cnt", {3'h0, i == 16, 4'(i)}, {3'h0, ovf, cnt});
        end
        {ctrl_wr, tgl} = 2'b00;
        step(3);
    endtask : t_strobe
    task automatic t_load();
        check("ovf_stays", 8'h01, {7'h0, ovf});
        stat(1'b1, 1'b0, 4'he);
        check("load", 8'h0e, {3'h0, ovf, cnt});
        {ctrl_wr, tgl} = 2'b11;
        step(2);
        {ctrl_wr, tgl} = 2'b00;
        step(1);
        check("sw_ovf", 8'h10, {3'h0, ovf, cnt});
    endtask : t_load
    task automatic t_timer();
        {cs1, str_sel} = 2'b00;
        stat(1'b1, 1'b0, 4'hf);
        tmr = 1'b1;
        step(1);
        tmr = 1'b0;
        step(1);
        check("tmr_ovf", 8'h10, {3'h0, ovf, cnt});
    endtask : t_timer
    task automatic t_spi();
        {wm, cs1, str_sel, edge_s} = {2'h1, 1'b1, 1'b0, 1'b0};
        pm.set_scl(1'b0);
        {d_wr, d_wd} = {1'b1, 8'ha5};
        step(1);
        d_wr = 1'b0;
        step(1);
        check("dout", 8'h01, {7'h0, dout});
        stat(1'b1, 1'b0, 4'h0);
        pm.send_byte(8'h3c);
        step(4);
        check("spi_rx", 8'h3c, sdr);
        check("spi_ovf", 8'h10, {3'h0, ovf, cnt});
        stat(1'b1, 1'b0, 4'hf);
        pm.set_scl(1'b1);
        step(4);
        check("edge_irq", 8'h10, {3'h0, ovf, cnt});
    endtask : t_spi
    task automatic t_off();
        for (int m = 0; m < 2; m++) begin
            wm = 2'(m);
            step(1);
            pm.start_cond();
            step(4);
            check("no_start", 8'h00,
                  {5'h0, sif, sda_oe, scl_oe});
            pm.stop_cond();
        end
    endtask : t_off
    task automatic t_twi();
        wm = 2'h3;
        {d_wr, d_wd} = {1'b1, 8'hff};
        step(1);
        d_wr = 1'b0;
        stat(1'b1, 1'b1, 4'h0);
        pm.start_cond();
        step(4);
        check("start", 8'h03, {6'h0, sif, scl_oe});
        step(20);
        check("hold", 8'h01, {7'h0, scl_oe});
        stat(1'b1, 1'b1, 4'h0);
        check("release", 8'h00, {6'h0, sif, scl_oe});
        pm.send_byte(8'ha6);
        step(4);
        check("twi_rx", 8'ha6, sdr);
        check("ovf_hold", 8'h03, {6'h0, ovf, scl_oe});
        stat(1'b1, 1'b0, 4'he);
        check("ack_rel", 8'h00, {7'h0, scl_oe});
        pm.set_scl(1'b1);
        pm.set_scl(1'b0);
        step(4);
        check("ack_ovf", 8'h03, {6'h0, ovf, scl_oe});
    endtask : t_twi
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        #1;
        rst_b = 1'b1;
        step(1);
        check("rst_sdr", 8'h00, sdr);
        check("rst_st", 8'h01, {3'h0, cnt != 4'h0, ovf, sif,
              sda_oe | scl_oe, sck});
        t_strobe();
        t_load();
        t_timer();
        t_spi();
        t_off();
        t_twi();
        check("scl_stuck", 8'h00, {7'h0, pm.stuck});
        end_sim();
    end
endmodule : ussu_core_tb
